// >>> rtl/spfm_mux.sv
/*
  Shared pin function mux for port B lines 3/4, the test-mode-select
  pin and port E lines 0..4. Assumes the outside pad cell resolves the
  wire from out/oe/pull and the analog switch is closed by ana.
*/
`timescale 1ns/1ps

// Notes on behaviour
// [R01] In reset pins are pulled-up inputs
// [R02] Each GPIO direction set per pin
// [R03] Port B line 3 GPIO default, five alternates
// [R04] MOSI drives in master, samples in slave
// [R05] MISO inverse; slave unselected releases line
// [R06] Port B line 4 GPIO default, six alternates
// [R07] Clock-out source from clock select field
// [R08] Analog use feeds both converters together
// [R09] Test pin defaults to test function
// [R10] Test select sampled on test clock rise
// [R11] Port E line 0 GPIO only
// [R12] Port E line 1 analog to B9, cmp0+
// [R13] Port E line 2 analog to B7, cmp0-
// [R14] Port E line 3 analog to A10, cmp2-
// [R15] Port E line 4 analog to A6, cmp2+
// [R16] Per-pin drive strength bit, 1 high
// [R17] Software select bits reset to defaults
module spfm_mux
  import spfm_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic [23:0]     func_sel,          // 3-bit select per pin
  input  wire logic            func_sel_we,       // Load func_sel
  input  wire spfm_gpio_type   gpio_cfg,          // Dir/data/drive
  input  wire logic            gpio_cfg_we,       // Load gpio_cfg
  input  wire logic [2:0]      clock_out_source_select, // Clock-out field
  input  wire logic            clock_sel_we,      // Load clock select
  input  wire spfm_periph_type periph,            // Peripheral signals
  input  wire logic [7:0]      pad_in,            // Pin levels
  input  wire logic            test_clk,          // Test clock as a level
  output spfm_pad_type         pad,               // Pad control
  output logic [7:0]           gpio_in,           // Sampled GPIO levels
  output logic                 spi_mosi_in,       // MOSI in slave mode
  output logic                 spi_miso_in,       // MISO in master mode
  output logic                 timer_input_ch3,   // Timer ch3 input
  output logic                 timer_io_ch0,      // Timer ch0 input
  output logic                 timer_io_ch1,      // Timer ch1 input
  output logic                 sda_in,            // I2C data in
  output logic                 sci_rx,            // Serial receive
  output logic                 test_mode_select,  // TMS to TAP
  output logic                 test_step,         // TMS sample strobe
  output logic [7:0]           ana_route,         // Analog routing flags
  output logic [23:0]          func_sel_q         // Current selects
);

  // Analog route bit positions
  localparam int AR_CH3  = 0;  // A3 and B3
  localparam int AR_CH0  = 1;  // A0 and B0
  localparam int AR_B11  = 2;
  localparam int AR_B9   = 3;  // Plus cmp0 +1
  localparam int AR_B7   = 4;  // Plus cmp0 -1
  localparam int AR_A10  = 5;  // Plus cmp2 -1
  localparam int AR_A6   = 6;  // Plus cmp2 +2

  spfm_gpio_type gcfg;          // Stored GPIO config
  logic [2:0]    clk_sel;       // Stored clock-out select
  logic [2:0]    sel [SPFM_NPINS];  // Unpacked select view
  logic          tclk_d;        // Previous test clock level
  spfm_pad_type  next_pad;      // Combinational pad control
  logic [7:0]    next_ana;      // Combinational analog route

  // Slice one pin's select from the flat register
  function automatic logic [2:0] pin_sel(input logic [23:0] s, input int i);
    pin_sel = s[3*i +: 3];
  endfunction : pin_sel

  // Default select word: GPIO everywhere, test on the TMS pin
  function automatic logic [23:0] sel_default();
    logic [23:0] d;
    d = '0;
    for (int i = 0; i < SPFM_NPINS; i++)
    begin
      d[3*i +: 3] = (i == SPFM_PIN_TMS) ? SPFM_TMS_SEL_TEST : SPFM_SEL_GPIO;
    end
    sel_default = d;
  endfunction : sel_default

  // Select register, reset to per-pin default
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      func_sel_q <= sel_default();  // [R17] [R03] [R06] [R09] [R11]
    end
    else if (func_sel_we)
    begin
      func_sel_q <= func_sel;  // [R17]
    end
  end

  // GPIO direction, data and drive per pin
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      gcfg <= '{dir: SPFM_RST_BITS, data: SPFM_RST_BITS, drive: SPFM_RST_BITS};
    end
    else if (gpio_cfg_we)
    begin
      gcfg <= gpio_cfg;  // [R02] [R16]
    end
  end

  // Clock-out source select field
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      clk_sel <= SPFM_CLK_SEL_RST;
    end
    else if (clock_sel_we)
    begin
      clk_sel <= clock_out_source_select;  // [R07]
    end
  end

  // Unpacked view for readability
  always_comb
  begin
    for (int i = 0; i < SPFM_NPINS; i++)
    begin
      sel[i] = pin_sel(func_sel_q, i);
    end
  end

  // Pad control per pin from its select
  always_comb
  begin
    next_pad       = '0;
    next_ana       = '0;
    next_pad.drive = gcfg.drive;  // [R16]
    next_pad.pull  = '0;
    // GPIO role on every pin except TMS, per-pin direction
    for (int i = 0; i < SPFM_NPINS; i++)
    begin
      if (sel[i] == SPFM_SEL_GPIO && i != SPFM_PIN_TMS)
      begin
        next_pad.oe[i]  = gcfg.dir[i];  // [R02]
        next_pad.out[i] = gcfg.data[i];
      end
    end
    // Port B line 3
    case (sel[SPFM_PIN_B3])
      SPFM_SEL_ALT1:  // SPI MOSI
      begin
        next_pad.oe[SPFM_PIN_B3]  = periph.spi_master;  // [R04]
        next_pad.out[SPFM_PIN_B3] = periph.spi_mosi;
      end
      SPFM_SEL_ALT3: next_ana[AR_CH3] = 1'b1;  // [R03] [R08]
      SPFM_SEL_ALT4:  // PWM 5
      begin
        next_pad.oe[SPFM_PIN_B3]  = 1'b1;
        next_pad.out[SPFM_PIN_B3] = periph.pulse_width_out_ch5;
      end
      SPFM_SEL_ALT5:  // Comparator 1 out
      begin
        next_pad.oe[SPFM_PIN_B3]  = 1'b1;
        next_pad.out[SPFM_PIN_B3] = periph.comparator_one_output;
      end
      default: ;  // GPIO or timer ch3 input
    endcase
    // Port B line 4
    case (sel[SPFM_PIN_B4])
      SPFM_SEL_ALT1:  // Timer ch0
      begin
        next_pad.oe[SPFM_PIN_B4]  = periph.tmr0_oe;
        next_pad.out[SPFM_PIN_B4] = periph.tmr0_out;
      end
      SPFM_SEL_ALT2:  // Buffered clock out
      begin
        next_pad.oe[SPFM_PIN_B4]  = 1'b1;
        next_pad.out[SPFM_PIN_B4] = periph.clk_srcs[clk_sel];  // [R07]
      end
      SPFM_SEL_ALT3:  // SPI MISO, released when unselected slave
      begin
        next_pad.oe[SPFM_PIN_B4]  = !periph.spi_master && !periph.spi_ss_n;  // [R05]
        next_pad.out[SPFM_PIN_B4] = periph.spi_miso;
      end
      SPFM_SEL_ALT4:  // I2C data, open drain
      begin
        next_pad.oe[SPFM_PIN_B4]  = periph.sda_low;  // [R06]
        next_pad.out[SPFM_PIN_B4] = 1'b0;
      end
      SPFM_SEL_ALT6: next_ana[AR_CH0] = 1'b1;  // [R06] [R08]
      default: ;  // GPIO or serial receive
    endcase
    // Test-mode-select pin
    case (sel[SPFM_PIN_TMS])
      SPFM_TMS_SEL_GPIO:  // Port D line 3
      begin
        next_pad.oe[SPFM_PIN_TMS]  = gcfg.dir[SPFM_PIN_TMS];  // [R02]
        next_pad.out[SPFM_PIN_TMS] = gcfg.data[SPFM_PIN_TMS];
      end
      SPFM_SEL_ALT2: next_ana[AR_B11] = 1'b1;  // [R09]
      SPFM_SEL_ALT3:  // Timer ch1
      begin
        next_pad.oe[SPFM_PIN_TMS]  = periph.tmr1_oe;
        next_pad.out[SPFM_PIN_TMS] = periph.tmr1_out;
      end
      SPFM_SEL_ALT4:  // Comparator output
      begin
        next_pad.oe[SPFM_PIN_TMS]  = 1'b1;
        next_pad.out[SPFM_PIN_TMS] = periph.cmp2_out;
      end
      default: next_pad.pull[SPFM_PIN_TMS] = 1'b1;  // Test input keeps pull-up
    endcase
    // Port E analog alternates; line 0 has none
    if (sel[SPFM_PIN_E1] == SPFM_SEL_ALT1) next_ana[AR_B9]  = 1'b1;  // [R12]
    if (sel[SPFM_PIN_E2] == SPFM_SEL_ALT1) next_ana[AR_B7]  = 1'b1;  // [R13]
    if (sel[SPFM_PIN_E3] == SPFM_SEL_ALT1) next_ana[AR_A10] = 1'b1;  // [R14]
    if (sel[SPFM_PIN_E4] == SPFM_SEL_ALT1) next_ana[AR_A6]  = 1'b1;  // [R15]
    // Analog pins are never driven digitally
    next_pad.ana[SPFM_PIN_B3]  = next_ana[AR_CH3];
    next_pad.ana[SPFM_PIN_B4]  = next_ana[AR_CH0];
    next_pad.ana[SPFM_PIN_TMS] = next_ana[AR_B11];
    next_pad.ana[SPFM_PIN_E1]  = next_ana[AR_B9];
    next_pad.ana[SPFM_PIN_E2]  = next_ana[AR_B7];
    next_pad.ana[SPFM_PIN_E3]  = next_ana[AR_A10];
    next_pad.ana[SPFM_PIN_E4]  = next_ana[AR_A6];
    for (int i = 0; i < SPFM_NPINS; i++)
    begin
      if (next_pad.ana[i])
      begin
        next_pad.oe[i] = 1'b0;
      end
    end
  end

  // Pad register: reset forces pulled-up inputs
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pad      <= '{out: SPFM_RST_BITS, oe: SPFM_RST_BITS, pull: SPFM_PULL_ON,
                    drive: SPFM_RST_BITS, ana: SPFM_RST_BITS};  // [R01]
      ana_route <= '0;
    end
    else
    begin
      pad       <= next_pad;
      ana_route <= next_ana;  // [R08]
    end
  end

  // Input sampling toward peripherals
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      gpio_in         <= '0;
      spi_mosi_in     <= 1'b0;
      spi_miso_in     <= 1'b0;
      timer_input_ch3 <= 1'b0;
      timer_io_ch0    <= 1'b0;
      timer_io_ch1    <= 1'b0;
      sda_in          <= 1'b1;
      sci_rx          <= 1'b1;
    end
    else
    begin
      gpio_in         <= pad_in;
      spi_mosi_in     <= (sel[SPFM_PIN_B3] == SPFM_SEL_ALT1) && !periph.spi_master
                         && pad_in[SPFM_PIN_B3];  // [R04]
      spi_miso_in     <= (sel[SPFM_PIN_B4] == SPFM_SEL_ALT3) && periph.spi_master
                         && pad_in[SPFM_PIN_B4];  // [R05]
      timer_input_ch3 <= (sel[SPFM_PIN_B3] == SPFM_SEL_ALT2) && pad_in[SPFM_PIN_B3];  // [R03]
      timer_io_ch0    <= (sel[SPFM_PIN_B4] == SPFM_SEL_ALT1) && pad_in[SPFM_PIN_B4];
      timer_io_ch1    <= (sel[SPFM_PIN_TMS] == SPFM_SEL_ALT3) && pad_in[SPFM_PIN_TMS];
      sda_in          <= (sel[SPFM_PIN_B4] != SPFM_SEL_ALT4) || pad_in[SPFM_PIN_B4];
      sci_rx          <= (sel[SPFM_PIN_B4] != SPFM_SEL_ALT5) || pad_in[SPFM_PIN_B4];
    end
  end

  // Test select sampled on test clock rising edge
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tclk_d           <= test_clk;  // Track the pin so no false edge follows reset
      test_step        <= 1'b0;
      test_mode_select <= 1'b1;
    end
    else
    begin
      tclk_d    <= test_clk;
      test_step <= test_clk && !tclk_d
                   && sel[SPFM_PIN_TMS] == SPFM_TMS_SEL_TEST;  // [R10]
      if (test_clk && !tclk_d && sel[SPFM_PIN_TMS] == SPFM_TMS_SEL_TEST)
      begin
        test_mode_select <= pad_in[SPFM_PIN_TMS];  // [R10] [R09]
      end
    end
  end

endmodule : spfm_mux

// >>> rtl/spfm_pkg.sv
/*
  Package for the shared pin function mux: function select codes,
  reset defaults and the packed structs that carry pin and peripheral
  signals. Assumes one system clock and a synchronous active-low reset.
*/
package spfm_pkg;

  // Function select codes, 3 bits per pin
  localparam logic [2:0] SPFM_SEL_GPIO   = 3'h0;  // General-purpose I/O
  localparam logic [2:0] SPFM_SEL_ALT1   = 3'h1;  // First alternate
  localparam logic [2:0] SPFM_SEL_ALT2   = 3'h2;  // Second alternate
  localparam logic [2:0] SPFM_SEL_ALT3   = 3'h3;  // Third alternate
  localparam logic [2:0] SPFM_SEL_ALT4   = 3'h4;  // Fourth alternate
  localparam logic [2:0] SPFM_SEL_ALT5   = 3'h5;  // Fifth alternate
  localparam logic [2:0] SPFM_SEL_ALT6   = 3'h6;  // Sixth alternate

  // Pin indices within the 8-pin group
  localparam int SPFM_PIN_B3  = 0;
  localparam int SPFM_PIN_B4  = 1;
  localparam int SPFM_PIN_TMS = 2;
  localparam int SPFM_PIN_E0  = 3;
  localparam int SPFM_PIN_E1  = 4;
  localparam int SPFM_PIN_E2  = 5;
  localparam int SPFM_PIN_E3  = 6;
  localparam int SPFM_PIN_E4  = 7;
  localparam int SPFM_NPINS   = 8;

  // Reset defaults and TMS pin select codes
  localparam logic [2:0] SPFM_TMS_SEL_TEST = 3'h0;  // Test function on TMS pin
  localparam logic [2:0] SPFM_TMS_SEL_GPIO = 3'h1;  // Port D bit 3
  localparam logic [7:0] SPFM_RST_BITS     = 8'h00;  // Dir, data, drive reset
  localparam logic [7:0] SPFM_PULL_ON      = 8'hff;  // All pull-ups during reset
  localparam logic [2:0] SPFM_CLK_SEL_RST  = 3'h0;  // Clock-out select reset

  // Per-pin pad signals toward the package
  typedef struct packed {
    logic [7:0] out;    // Output level
    logic [7:0] oe;     // Output enable, high when driving
    logic [7:0] pull;   // Pull-up enable
    logic [7:0] drive;  // Drive strength, 1 = high
    logic [7:0] ana;    // Analog switch closed
  } spfm_pad_type;

  // Per-pin software configuration
  typedef struct packed {
    logic [7:0] dir;    // 1 = output for GPIO
    logic [7:0] data;   // GPIO output data
    logic [7:0] drive;  // Drive strength bit
  } spfm_gpio_type;

  // Digital peripheral inputs to the mux
  typedef struct packed {
    logic       spi_master;    // SPI in master mode
    logic       spi_ss_n;      // Slave selected, active low
    logic       spi_mosi;      // MOSI data from SPI
    logic       spi_miso;      // MISO data from SPI
    logic       pulse_width_out_ch5;          // PWM channel 5
    logic       comparator_one_output;      // Comparator 1 output
    logic       cmp2_out;      // Comparator 2 output
    logic       tmr0_out;      // Timer ch0 output
    logic       tmr0_oe;       // Timer ch0 drives
    logic       tmr1_out;      // Timer ch1 output
    logic       tmr1_oe;       // Timer ch1 drives
    logic       sda_low;       // I2C pulls SDA low
    logic [7:0] clk_srcs;      // Candidate clock-out sources
  } spfm_periph_type;

endpackage : spfm_pkg

// >>> testbench/spfm_mux_assertions.sv
/* Checker for the shared pin mux: pad and route timing at its ports.
   Assumes it is bound onto spfm_mux and sees only that module's ports. */
`timescale 1ns/1ps
module spfm_mux_assertions
  import spfm_pkg::*;
(
  input wire logic            clk,
  input wire logic            resetn,
  input wire logic [23:0]     func_sel,
  input wire logic            func_sel_we,
  input wire spfm_gpio_type   gpio_cfg,
  input wire logic            gpio_cfg_we,
  input wire logic [2:0]      clock_out_source_select,
  input wire logic            clock_sel_we,
  input wire spfm_periph_type periph,
  input wire logic [7:0]      pad_in,
  input wire logic            test_clk,
  input wire spfm_pad_type    pad,
  input wire logic            test_mode_select,
  input wire logic            test_step,
  input wire logic [7:0]      ana_route,
  input wire logic [23:0]     func_sel_q
);
  logic [2:0]    csel;  // Shadow of the clock-out select
  spfm_gpio_type gc;    // Shadow of the GPIO config

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Shadows load on the same edge as the block's own registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      csel <= SPFM_CLK_SEL_RST;
      gc   <= '0;
    end
    else
    begin
      if (clock_sel_we) csel <= clock_out_source_select;
      if (gpio_cfg_we) gc <= gpio_cfg;
    end
  end

  a_reset_pins:
    assert property (disable iff (1'b0) !resetn |=> pad.oe == 8'h00 && pad.pull == 8'hff)
    else $error("Pins not pulled-up inputs in reset");
  a_sel_load:
    assert property (func_sel_we |=> func_sel_q == $past(func_sel))
    else $error("Select readback wrong");
  a_mosi_drive:
    assert property (func_sel_q[2:0] == 3'h1 && periph.spi_master
      |=> pad.oe[0] && pad.out[0] == $past(periph.spi_mosi))
    else $error("MOSI not driven in master mode");
  a_miso_release:
    assert property (func_sel_q[5:3] == 3'h3 && (periph.spi_master || periph.spi_ss_n)
      |=> !pad.oe[1])
    else $error("MISO driven while it must float");
  a_clk_route:
    assert property (func_sel_q[5:3] == 3'h2
      |=> pad.oe[1] && pad.out[1] == $past(periph.clk_srcs[csel]))
    else $error("Clock output source wrong");
  a_ana_both:
    assert property (func_sel_q[2:0] == 3'h3 |=> ana_route[0] && pad.ana[0] && !pad.oe[0])
    else $error("Analog route not closed");
  a_test_sample:
    assert property ($rose(test_clk) && func_sel_q[8:6] == 3'h0
      |=> test_step && test_mode_select == $past(pad_in[2]))
    else $error("Test select not sampled");
  a_gpio_dir:
    assert property (func_sel_q[11:9] == 3'h0
      |=> pad.oe[3] == $past(gc.dir[3]) && pad.drive[3] == $past(gc.drive[3]))
    else $error("GPIO direction or drive wrong");
  a_sda_open:
    assert property (func_sel_q[5:3] == 3'h4
      |=> !pad.out[1] && pad.oe[1] == $past(periph.sda_low))
    else $error("Open-drain data line drives high");
endmodule : spfm_mux_assertions

bind spfm_mux spfm_mux_assertions u_spfm_mux_assertions (
  .clk(clk), .resetn(resetn), .func_sel(func_sel), .func_sel_we(func_sel_we),
  .gpio_cfg(gpio_cfg), .gpio_cfg_we(gpio_cfg_we), .periph(periph), .pad_in(pad_in),
  .clock_out_source_select(clock_out_source_select), .clock_sel_we(clock_sel_we),
  .test_clk(test_clk), .pad(pad), .test_mode_select(test_mode_select),
  .test_step(test_step), .ana_route(ana_route), .func_sel_q(func_sel_q)
);

// >>> testbench/spfm_board.sv
/* Board model: resolves each pin from the chip, the board and the pull-up.
   Assumes the bench sets board driver enables and levels. */
`timescale 1ns/1ps
module spfm_board
  import spfm_pkg::*;
(
  input  wire logic         clk,
  input  wire spfm_pad_type pad,
  input  wire logic [7:0]   bd_en,
  input  wire logic [7:0]   bd_lvl,
  output logic [7:0]        pad_in
);
  logic [7:0] tog = 8'h55;  // Floating pins wander

  // Undriven, unpulled pins change every cycle
  always @(posedge clk)
  begin
    tog <= ~tog;
  end

  // Chip first, then board, then pull-up, else floating
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pad_in[i] = pad.oe[i] ? pad.out[i] : bd_en[i] ? bd_lvl[i] : pad.pull[i] | tog[i];
  end
endmodule : spfm_board

// >>> testbench/test_shared_pin_function_mux.sv
/* Self-checking bench for the shared pin mux, one task per scenario.
   Assumes spfm_board resolves the pins and the checker is bound. */
`timescale 1ns/1ps
module test_shared_pin_function_mux
  import spfm_pkg::*;
;
  logic            clk = 1'b0;
  logic            resetn = 1'b0;
  logic [23:0]     fs = 24'h0;
  logic            fs_we = 1'b0;
  spfm_gpio_type   gcfg = '0;
  logic            g_we = 1'b0;
  logic [2:0]      csel = 3'h0;
  logic            c_we = 1'b0;
  spfm_periph_type per = '0;
  logic            test_clk = 1'b0;
  logic [7:0]      bd_en = 8'h00;
  logic [7:0]      bd_lvl = 8'h00;
  spfm_pad_type    pad;
  logic [7:0]      pad_in, gpio_in, ana_route;
  logic            mosi_in, miso_in, tms, step;
  logic            tmr3_in, tmr0_in, tmr1_in, sda_in, sci_rx;
  logic [23:0]     fsq;
  int              fail_count = 0;
  int              cmp_count = 0;

  spfm_mux u_spfm_mux (.clk(clk), .resetn(resetn), .func_sel(fs), .func_sel_we(fs_we),
    .gpio_cfg(gcfg), .gpio_cfg_we(g_we), .clock_out_source_select(csel),
    .clock_sel_we(c_we), .periph(per), .pad_in(pad_in), .test_clk(test_clk), .pad(pad),
    .gpio_in(gpio_in), .spi_mosi_in(mosi_in), .spi_miso_in(miso_in),
    .timer_input_ch3(tmr3_in), .timer_io_ch0(tmr0_in), .timer_io_ch1(tmr1_in),
    .sda_in(sda_in), .sci_rx(sci_rx),
    .test_mode_select(tms), .test_step(step), .ana_route(ana_route), .func_sel_q(fsq));
  spfm_board u_spfm_board (.clk(clk), .pad(pad), .bd_en(bd_en), .bd_lvl(bd_lvl),
    .pad_in(pad_in));

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Select write, then wait until the pads follow
  task automatic sel(input int p, input logic [2:0] c);
    fs[3*p +: 3] = c;
    fs_we = 1'b1;
    tick(1);
    fs_we = 1'b0;
    tick(2);
  endtask : sel

  task automatic t_reset;
    chk(pad.pull, 8'hff);
    chk(pad.oe, 8'h00);
    resetn = 1'b1;
    tick(2);
    chk(fsq, 24'h0);
    chk(pad.pull[2], 1'b1);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_gpio;
    gcfg = '{dir: 8'h09, data: 8'h08, drive: 8'h08};
    bd_en = 8'h10;
    bd_lvl = 8'h10;
    g_we = 1'b1;
    tick(1);
    g_we = 1'b0;
    tick(2);
    chk(pad.oe, 8'h09);
    chk(pad.out & 8'h09, 8'h08);
    chk(pad.drive & 8'h09, 8'h08);
    chk(gpio_in[4], 1'b1);
    $display("t_gpio done");
  endtask : t_gpio

  task automatic t_spi;
    per.spi_master = 1'b1;
    per.spi_mosi = 1'b1;
    sel(0, 3'h1);
    chk({pad.oe[0], pad.out[0]}, 2'b11);
    per.spi_master = 1'b0;
    bd_en = 8'h03;
    bd_lvl = 8'h03;
    tick(2);
    chk({pad.oe[0], mosi_in}, 2'b01);
    per.spi_master = 1'b1;
    sel(1, 3'h3);
    chk({pad.oe[1], miso_in}, 2'b01);
    per.spi_master = 1'b0;
    per.spi_miso = 1'b1;
    tick(2);
    chk({pad.oe[1], pad.out[1]}, 2'b11);
    per.spi_ss_n = 1'b1;
    tick(2);
    chk(pad.oe[1], 1'b0);
    $display("t_spi done");
  endtask : t_spi

  task automatic t_outs;
    int         p[6] = '{0, 0, 1, 1, 2, 2};
    logic [2:0] c[6] = '{3'h4, 3'h5, 3'h1, 3'h4, 3'h3, 3'h4};
    logic       x[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    per = '{pulse_width_out_ch5: 1'b1, comparator_one_output: 1'b0, cmp2_out: 1'b1, tmr0_out: 1'b1, tmr0_oe: 1'b1,
      tmr1_out: 1'b0, tmr1_oe: 1'b1, sda_low: 1'b1, clk_srcs: 8'h20, default: 1'b0};
    bd_en = 8'h00;
    for (int i = 0; i < 6; i++)
    begin
      sel(p[i], c[i]);
      chk({pad.oe[p[i]], pad.out[p[i]]}, {1'b1, x[i]});
    end
    csel = 3'h5;
    c_we = 1'b1;
    tick(1);
    c_we = 1'b0;
    sel(1, 3'h2);
    chk({pad.oe[1], pad.out[1]}, 2'b11);
    per.clk_srcs = 8'hdf;
    tick(2);
    chk(pad.out[1], 1'b0);
    $display("t_outs done");
  endtask : t_outs

  task automatic t_ana;
    int         p[7] = '{0, 1, 2, 4, 5, 6, 7};
    logic [2:0] c[7] = '{3'h3, 3'h6, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1};
    fs = 24'h0;
    sel(0, 3'h0);
    for (int i = 0; i < 7; i++)
    begin
      sel(p[i], c[i]);
      chk(ana_route, 8'h01 << i);
      chk(pad.ana[p[i]], 1'b1);
      sel(p[i], 3'h0);
    end
    $display("t_ana done");
  endtask : t_ana

  task automatic t_test;
    bd_en = 8'h04;
    bd_lvl = 8'h00;
    tick(2);
    test_clk = 1'b1;
    tick(1);
    chk({step, tms}, 2'b10);
    tick(1);
    chk(step, 1'b0);
    bd_lvl = 8'h04;
    test_clk = 1'b0;
    tick(1);
    test_clk = 1'b1;
    tick(1);
    chk({step, tms}, 2'b11);
    $display("t_test done");
  endtask : t_test

  // Peripheral inputs follow their pin, then a mid-run reset
  task automatic t_ins;
    per = '0;
    bd_en = 8'h07;
    bd_lvl = 8'h00;
    sel(0, 3'h2);
    sel(1, 3'h1);
    sel(2, 3'h3);
    bd_lvl = 8'h07;
    tick(2);
    chk(tmr3_in, 1'b1);
    chk(tmr0_in, 1'b1);
    chk(tmr1_in, 1'b1);
    bd_lvl = 8'h00;
    tick(2);
    chk({tmr3_in, tmr0_in, tmr1_in}, 3'b000);
    sel(1, 3'h4);
    chk({sda_in, sci_rx}, 2'b01);
    sel(1, 3'h5);
    chk({sda_in, sci_rx}, 2'b10);
    resetn = 1'b0;
    tick(1);
    chk(pad.oe, 8'h00);
    chk(pad.pull, 8'hff);
    chk(fsq, 24'h0);
    resetn = 1'b1;
    tick(1);
    chk({step, tms}, 2'b01);
    $display("t_ins done");
  endtask : t_ins

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Main sequence after 12 cycles of reset
  initial
  begin
    tick(12);
    t_reset;
    t_gpio;
    t_spi;
    t_outs;
    t_ana;
    t_test;
    t_ins;
    wrap_up;
  end

  // Watchdog, far beyond the 125 or so cycles the tests need
  initial
  begin
    #50000;
    fail_count++;
    wrap_up;
  end
endmodule : test_shared_pin_function_mux
